// ### bench/dtc_pin_partner.sv
// Model of the external gate, count and toggle pins of both timers
`timescale 1ns/10ps
module dtc_pin_partner (
   input  wire logic       clock,
   input  wire logic [1:0] count_pin_out,
   input  wire logic [1:0] count_pin_oe,
   output logic [1:0]      ext_irq_pin,
   output logic [1:0]      count_pin_in
);
   logic [1:0] irq_level = 2'b11;
   logic [1:0] cnt_level = 2'b11;

   // Shared pin: core value while enabled, else the external count source
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         count_pin_in[i] = count_pin_oe[i] ? count_pin_out[i] : cnt_level[i];
      end
   end

   assign ext_irq_pin = irq_level;

   // Gate pin moves just after a clock edge
   task automatic set_irq(input int idx, input logic val);
      @(posedge clock);
      irq_level[idx] <= val;
   endtask : set_irq

   // Count source: n low pulses, each level held four clocks
   task automatic pulse_count(input int idx, input int n);
      repeat (n) begin
         repeat (4) @(posedge clock);
         cnt_level[idx] <= 1'b0;
         repeat (4) @(posedge clock);
         cnt_level[idx] <= 1'b1;
      end
   endtask : pulse_count
endmodule : dtc_pin_partner

// ### bench/test_dual_timer_counter_modes.sv
// Self-checking bench for the dual timer/counter core
`timescale 1ns/10ps
module test_dual_timer_counter_modes;
   import dtc_pkg::*;
   logic         clock;
   logic         sys_rst;
   dtc_bus_type  bus;
   logic [7:0]   rdata;
   dtc_irq_type  irq_ack;
   dtc_irq_type  irq_flags;
   logic [1:0]   ext_irq_pin;
   logic [1:0]   count_pin_in;
   logic [1:0]   count_pin_out;
   logic [1:0]   count_pin_oe;
   logic         rd_q = 1'b0;
   logic [31:0]  lfsr = 32'h42ca_7aa3;
   logic [7:0]   exp_q[$];
   int           n_mismatch = 0;
   int           tests_run = 0;

   dtc_timer_core u_dtc_timer_core (.clock(clock), .sys_rst(sys_rst), .bus(bus), .rdata(rdata),
      .irq_ack(irq_ack), .irq_flags(irq_flags), .ext_irq_pin(ext_irq_pin), .count_pin_in(count_pin_in),
      .count_pin_out(count_pin_out), .count_pin_oe(count_pin_oe));
   dtc_pin_partner u_dtc_pin_partner (.clock(clock), .count_pin_out(count_pin_out),
      .count_pin_oe(count_pin_oe), .ext_irq_pin(ext_irq_pin), .count_pin_in(count_pin_in));

   //****************************************************************
   // Clock, tasks and read monitor
   //****************************************************************
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clock);
      bus <= '0;
   endtask : wr_reg

   // Read: note the expected value, the monitor compares it
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clock);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      exp_q.push_back(exp);
      @(posedge clock);
      bus <= '0;
   endtask : rd_reg

   task automatic idle(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : idle

   // Read data stand only in the cycle after the strobe
   always @(posedge clock) begin
      rd_q <= bus.rd;
      if (rd_q === 1'b1 && exp_q.size() > 0) check(rdata, exp_q.pop_front());
   end

   task automatic tally_and_finish;
      $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish

   // Watchdog well beyond the expected run
   initial begin
      #20000;
      n_mismatch++;
      tally_and_finish();
   end

   //****************************************************************
   // Main sequence
   //****************************************************************
   initial begin
      sys_rst = 1'b1;
      bus = '0;
      irq_ack = '0;
      repeat (5) @(posedge clock);
      sys_rst <= 1'b0;
      rd_reg(8'h88, 8'h00);
      rd_reg(8'h55, 8'h00);
      $display("test reset done");
      wr_reg(8'h89, 8'h09);
      wr_reg(8'h8A, 8'hFF);
      wr_reg(8'h8C, 8'hFF);
      u_dtc_pin_partner.set_irq(0, 1'b0);
      wr_reg(8'h88, 8'h10);
      idle(10);
      rd_reg(8'h8A, 8'hFF);
      u_dtc_pin_partner.set_irq(0, 1'b1);
      idle(10);
      rd_reg(8'h88, 8'h32);
      rd_reg(8'h8C, 8'h00);
      wr_reg(8'h88, 8'h00);
      rd_reg(8'h88, 8'h00);
      $display("test gate done");
      wr_reg(8'h89, 8'h00);
      wr_reg(8'h8A, 8'h1F);
      wr_reg(8'h8C, 8'hFF);
      wr_reg(8'h88, 8'h10);
      idle(6);
      rd_reg(8'h88, 8'h30);
      rd_reg(8'h8C, 8'h00);
      @(posedge clock);
      irq_ack <= 4'b0100;
      @(posedge clock);
      irq_ack <= '0;
      rd_reg(8'h88, 8'h10);
      wr_reg(8'h88, 8'h00);
      $display("test mode0 done");
      wr_reg(8'h89, 8'h02);
      wr_reg(8'h8C, 8'hF0);
      wr_reg(8'h8A, 8'hFE);
      wr_reg(8'h88, 8'h10);
      idle(6);
      rd_reg(8'h88, 8'h30);
      rd_reg(8'h8C, 8'hF0);
      $display("test reload done");
      wr_reg(8'h88, 8'h05);
      u_dtc_pin_partner.set_irq(0, 1'b0);
      idle(8);
      rd_reg(8'h88, 8'h07);
      wr_reg(8'h88, 8'h05);
      rd_reg(8'h88, 8'h05);
      u_dtc_pin_partner.set_irq(0, 1'b1);
      $display("test edge done");
      wr_reg(8'h89, 8'h01);
      wr_reg(8'h8A, 8'hF0);
      wr_reg(8'h8C, 8'hFF);
      wr_reg(8'hA2, 8'h01);
      idle(3);
      check({6'h00, count_pin_oe[0], count_pin_out[0]}, 8'h03);
      wr_reg(8'h88, 8'h10);
      idle(40);
      check({6'h00, count_pin_oe[0], count_pin_out[0]}, 8'h02);
      wr_reg(8'h88, 8'h00);
      $display("test toggle done");
      for (int i = 0; i < 4; i++) begin
         lfsr = lfsr_next(lfsr);
         wr_reg(8'h8B, lfsr[7:0]);
         rd_reg(8'h8B, lfsr[7:0]);
      end
      idle(3);
      $display("test readback done");
      // Counter mode: falling edges on the count pin
      wr_reg(8'h89, 8'h05);
      wr_reg(8'h8A, 8'h00);
      wr_reg(8'h88, 8'h10);
      u_dtc_pin_partner.pulse_count(0, 3);
      idle(8);
      check({6'h00, count_pin_oe[0], count_pin_out[0]}, 8'h00);
      rd_reg(8'h8A, 8'h03);
      $display("test counter done");
      // Timer 0 split, then timer 1 stopped by its own mode 3
      wr_reg(8'h88, 8'h40);
      wr_reg(8'h89, 8'h03);
      wr_reg(8'h8A, 8'h33);
      wr_reg(8'h8C, 8'hF8);
      idle(12);
      rd_reg(8'h88, 8'hC0);
      rd_reg(8'h8A, 8'h33);
      wr_reg(8'h89, 8'h33);
      wr_reg(8'h8B, 8'h5A);
      idle(4);
      rd_reg(8'h8B, 8'h5A);
      $display("test split done");
      // Timer 1 PWM from a low byte of 5A
      wr_reg(8'h88, 8'h00);
      wr_reg(8'h89, 8'h20);
      wr_reg(8'h8F, 8'h10);
      wr_reg(8'h8D, 8'h80);
      wr_reg(8'h88, 8'h40);
      rd_reg(8'h88, 8'h40);
      idle(130);
      check({6'h00, count_pin_oe[1], count_pin_out[1]}, 8'h03);
      rd_reg(8'h88, 8'hC0);
      wr_reg(8'h8B, 8'h10);
      rd_reg(8'h8B, 8'h11);
      wr_reg(8'h8D, 8'hFF);
      idle(2);
      check({6'h00, count_pin_oe[1], count_pin_out[1]}, 8'h02);
      wr_reg(8'h8D, 8'h00);
      idle(2);
      check({6'h00, count_pin_oe[1], count_pin_out[1]}, 8'h03);
      $display("test pwm done");
      tally_and_finish();
   end
endmodule : test_dual_timer_counter_modes

// ### logic/dtc_pin_sync.sv
// Two-stage pin synchroniser with sampled falling-edge detect
`timescale 1ns/10ps
module dtc_pin_sync (
   input  wire logic clock,
   input  wire logic sys_rst,
   input  wire logic pin_async,
   input  wire logic sample,
   output logic      level,
   output logic      fall
);
   logic meta;
   logic sync;
   logic held;

   // Two flip-flops before any logic reads the pin
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         meta <= 1'b1;
         sync <= 1'b1;
      end else begin
         meta <= pin_async;
         sync <= meta;
      end
   end

   // R26: high then low at two samples
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         held <= 1'b1;
         fall <= 1'b0;
      end else if (sample) begin
         held <= sync;
         fall <= held & ~sync;
      end else begin
         fall <= 1'b0;
      end
   end

   assign level = sync;

endmodule : dtc_pin_sync

// ### logic/dtc_pkg.sv
// Constants, types and mode decode for the dual timer/counter block
//****************************************************************
// Function
// R1: Mode 0 counts 13 bits and sets the overflow flag on wrap to zero.
// R2: Mode 0 count is high byte above low five bits; upper low bits ignored.
// R3: Count only while run is 1 and gate is 0 or irq pin is high.
// R4: Setting the run bit resumes counting without clearing the count bytes.
// R5: Mode 1 is mode 0 using all sixteen bits, no prescaler.
// R6: Mode 2 low byte counts, sets flag and reloads from unchanged high byte.
// R7: Timer 1 in mode 3 stops as if its run bit were cleared.
// R8: Timer 0 mode 3 low byte is an 8-bit counter with timer 0 controls.
// R9: Timer 0 mode 3 high byte counts cycles using timer 1 run and flag.
// R10: With timer 0 in mode 3, timer 1 runs unless in its own mode 3.
// R11: Mode 6 is a PWM with a period of 256 timer clocks.
// R12: Mode 6 flag is low for high-byte clocks, high for 256 minus that.
// R13: Software keeps the mode 6 high byte between 1 and 254.
// R14: Mode 6 pin forced high for high byte 00h, low for FFh.
// R15: Mode 6 flag set and cleared by hardware; software may still clear it.
// R16: Outside mode 6 overflow sets flags; cleared by vector acknowledge or software.
// R17: Run bits 4 and 6 are software controlled on/off for both timers.
// R18: Type bits 0 and 2 select falling edge when set, low level when clear.
// R19: Edge flags 1 and 3 set on detected edge; cleared on acknowledge or software.
// R20: With toggle enable set, each overflow inverts the timer pin.
// R21: After toggle enable the pin is 1 until the first overflow.
// R22: Software clears the counter select for the toggle output to work.
// R23: Mode codes 000,001,010,011,110 decode to modes 0,1,2,3,6; rest reserved.
// R24: Counter select clear counts core clocks; set counts count pin events.
// R25: A software count-byte write beats a same-cycle increment or reload.
// R26: Count pin synchronised, counted on falling edge, once per machine cycle.
//****************************************************************
package dtc_pkg;

   // Register addresses
   localparam logic [7:0] ADDR_CONTROL  = 8'h88;
   localparam logic [7:0] ADDR_MODE     = 8'h89;
   localparam logic [7:0] ADDR_AUX_MODE = 8'h8F;
   localparam logic [7:0] ADDR_AUX_CTRL = 8'hA2;
   localparam logic [7:0] ADDR_LOW [2]  = '{8'h8A, 8'h8B};
   localparam logic [7:0] ADDR_HIGH [2] = '{8'h8C, 8'h8D};

   // Control register fields, per timer / per interrupt
   localparam int CTRL_IT [2] = '{0, 2};
   localparam int CTRL_IE [2] = '{1, 3};
   localparam int CTRL_TR [2] = '{4, 6};
   localparam int CTRL_TF [2] = '{5, 7};
   // Mode register: a four-bit field per timer
   localparam int MODE_STRIDE = 4;
   localparam int MODE_CT     = 2;
   localparam int MODE_GATE   = 3;
   localparam int TOGGLE_BIT [2] = '{0, 1};

   // Reset values and count limits
   localparam logic [7:0]  REG_RESET = 8'h00;
   localparam logic [7:0]  BYTE_MAX  = 8'hFF;
   localparam logic [7:0]  BYTE_ZERO = 8'h00;
   localparam logic [4:0]  LOW5_MAX  = 5'h1F;
   localparam logic [12:0] ONE13     = 13'h0001;
   localparam logic [15:0] ONE16     = 16'h0001;
   localparam logic [7:0]  ONE8      = 8'h01;
   localparam int MC_CLOCKS_DEF = 2;

   // Operating modes
   typedef enum logic [2:0] {
      DTC_MODE_13BIT,
      DTC_MODE_16BIT,
      DTC_MODE_RELOAD,
      DTC_MODE_SPLIT,
      DTC_MODE_PWM,
      DTC_MODE_RESERVED
   } dtc_mode_type;

   // Register bus request
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } dtc_bus_type;

   // Interrupt flags and acknowledges
   typedef struct packed {
      logic tf1;
      logic tf0;
      logic ie1;
      logic ie0;
   } dtc_irq_type;

   // R23: mode code decode
   function automatic dtc_mode_type dtc_decode_mode(input logic [2:0] code);
      dtc_mode_type m;
      m = DTC_MODE_RESERVED;
      if (code == 3'h0) m = DTC_MODE_13BIT;
      else if (code == 3'h1) m = DTC_MODE_16BIT;
      else if (code == 3'h2) m = DTC_MODE_RELOAD;
      else if (code == 3'h3) m = DTC_MODE_SPLIT;
      else if (code == 3'h6) m = DTC_MODE_PWM;
      return m;
   endfunction : dtc_decode_mode

endpackage : dtc_pkg

// ### logic/dtc_timer_core.sv
// Dual timer/counter with modes 0,1,2,3,6, control register and toggle pins
`timescale 1ns/10ps
module dtc_timer_core
   import dtc_pkg::*;
#(
   parameter int MC_CLOCKS = MC_CLOCKS_DEF
) (
   input  wire logic         clock,
   input  wire logic         sys_rst,
   input  wire dtc_bus_type  bus,
   output logic [7:0]        rdata,
   input  wire dtc_irq_type  irq_ack,
   output dtc_irq_type       irq_flags,
   input  wire logic [1:0]   ext_irq_pin,
   input  wire logic [1:0]   count_pin_in,
   output logic [1:0]        count_pin_out,
   output logic [1:0]        count_pin_oe
);
   localparam int MC_W = $clog2(MC_CLOCKS) + 1;

   //****************************************************************
   // Declarations
   //****************************************************************
   logic [7:0]    timer_mode_reg;
   logic [1:0]    timer_aux_mode_reg;
   logic [1:0]    toggle_enable;
   logic [1:0]    run_bit;
   logic [1:0]    irq_type_select;
   logic [1:0]    overflow_flag;
   logic [1:0]    irq_edge_flag;
   logic [7:0]    count_low_byte [2];
   logic [7:0]    count_high_byte [2];
   logic [7:0]    next_low [2];
   logic [7:0]    next_high [2];
   logic [7:0]    next_split_high;
   logic [1:0]    ovf;
   logic          ovf_split;
   logic [1:0]    cnt_en;
   logic [1:0]    run_eff;
   logic [1:0]    wr_low;
   logic [1:0]    wr_high;
   logic          wr_ctrl;
   logic          split0;
   logic          split_en;
   logic [1:0]    flag_set;
   logic [1:0]    pwm_flag_mode;
   logic [1:0]    ext_level;
   logic [1:0]    ext_fall;
   logic [1:0]    cnt_fall;
   logic [MC_W-1:0] mc_count;
   logic          mc_tick;
   dtc_mode_type  mode [2];

   //****************************************************************
   // Bus decode and machine cycle
   //****************************************************************
   assign wr_ctrl = bus.wr && (bus.addr == ADDR_CONTROL);
   assign mc_tick = (mc_count == MC_W'(MC_CLOCKS - 1));

   // Machine cycle divider for count pin sampling
   always_ff @(posedge clock) begin
      if (sys_rst) mc_count <= '0;
      else if (mc_tick) mc_count <= '0;
      else mc_count <= MC_W'(mc_count + 1'b1);
   end

   // Software control bits
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         timer_mode_reg     <= REG_RESET;
         timer_aux_mode_reg <= 2'h0;
         toggle_enable      <= 2'h0;
         run_bit            <= 2'h0;
         irq_type_select    <= 2'h0;
      end else begin
         if (bus.wr && bus.addr == ADDR_MODE) timer_mode_reg <= bus.wdata;
         if (bus.wr && bus.addr == ADDR_AUX_MODE)
            timer_aux_mode_reg <= {bus.wdata[MODE_STRIDE], bus.wdata[0]};
         if (bus.wr && bus.addr == ADDR_AUX_CTRL)
            toggle_enable <= {bus.wdata[TOGGLE_BIT[1]], bus.wdata[TOGGLE_BIT[0]]};
         // R17: run bits written by software
         if (wr_ctrl) begin
            run_bit         <= {bus.wdata[CTRL_TR[1]], bus.wdata[CTRL_TR[0]]};
            // R18: edge or level select
            irq_type_select <= {bus.wdata[CTRL_IT[1]], bus.wdata[CTRL_IT[0]]};
         end
      end
   end

   //****************************************************************
   // Pin synchronisers and per-timer enables
   //****************************************************************
   assign split0 = (mode[0] == DTC_MODE_SPLIT);

   for (genvar n = 0; n < 2; n++) begin : g_chan
      dtc_pin_sync u_irq_sync (
         .clock     (clock),
         .sys_rst   (sys_rst),
         .pin_async (ext_irq_pin[n]),
         .sample    (1'b1),
         .level     (ext_level[n]),
         .fall      (ext_fall[n])
      );
      // R26: count pin sampled once per machine cycle
      dtc_pin_sync u_cnt_sync (
         .clock     (clock),
         .sys_rst   (sys_rst),
         .pin_async (count_pin_in[n]),
         .sample    (mc_tick),
         .level     (),
         .fall      (cnt_fall[n])
      );
      assign wr_low[n]  = bus.wr && (bus.addr == ADDR_LOW[n]);
      assign wr_high[n] = bus.wr && (bus.addr == ADDR_HIGH[n]);
      assign mode[n] = dtc_decode_mode({timer_aux_mode_reg[n],
                                        timer_mode_reg[MODE_STRIDE*n +: 2]});
      // R3: run and gate qualify counting; R24: clock or pin events
      assign cnt_en[n] = run_eff[n]
                       & (~timer_mode_reg[MODE_STRIDE*n + MODE_GATE] | ext_level[n])
                       & (timer_mode_reg[MODE_STRIDE*n + MODE_CT] ? cnt_fall[n] : 1'b1);
   end

   // R7: timer 1 mode 3 stops; R10: otherwise free-runs while timer 0 splits
   assign run_eff[0] = run_bit[0];
   assign run_eff[1] = (mode[1] == DTC_MODE_SPLIT) ? 1'b0 : (split0 ? 1'b1 : run_bit[1]);
   // R9: split high byte counts core cycles under timer 1 run bit
   assign split_en = split0 && run_bit[1];

   //****************************************************************
   // Next count values
   //****************************************************************
   always_comb begin
      for (int n = 0; n < 2; n++) begin
         next_low[n]  = count_low_byte[n];
         next_high[n] = count_high_byte[n];
         ovf[n]       = 1'b0;
         if (cnt_en[n]) begin
            case (mode[n])
               DTC_MODE_13BIT: begin
                  // R1: 13-bit count; R2: low five bits as prescaler
                  {next_high[n], next_low[n][4:0]} = {count_high_byte[n], count_low_byte[n][4:0]} + ONE13;
                  ovf[n] = (count_high_byte[n] == BYTE_MAX) && (count_low_byte[n][4:0] == LOW5_MAX);
               end
               DTC_MODE_16BIT: begin
                  // R5: full 16 bits, no prescaler
                  {next_high[n], next_low[n]} = {count_high_byte[n], count_low_byte[n]} + ONE16;
                  ovf[n] = ({count_high_byte[n], count_low_byte[n]} == {BYTE_MAX, BYTE_MAX});
               end
               DTC_MODE_RELOAD: begin
                  // R6: reload low byte from high byte
                  ovf[n] = (count_low_byte[n] == BYTE_MAX);
                  next_low[n] = ovf[n] ? count_high_byte[n] : count_low_byte[n] + ONE8;
               end
               DTC_MODE_SPLIT, DTC_MODE_PWM: begin
                  // R8: low byte 8-bit counter; R11: 256-clock PWM period
                  ovf[n] = (count_low_byte[n] == BYTE_MAX);
                  next_low[n] = count_low_byte[n] + ONE8;
               end
               default: begin
                  ovf[n] = 1'b0;
               end
            endcase
         end
      end
   end

   // R9: split high byte increment and overflow
   assign next_split_high = count_high_byte[0] + ONE8;
   assign ovf_split = split_en && (count_high_byte[0] == BYTE_MAX);

   //****************************************************************
   // Count bytes
   //****************************************************************
   for (genvar n = 0; n < 2; n++) begin : g_count
      // R25: software write beats hardware; R4: run never clears counts
      always_ff @(posedge clock) begin
         if (sys_rst) begin
            count_low_byte[n]  <= REG_RESET;
            count_high_byte[n] <= REG_RESET;
         end else begin
            if (wr_low[n]) count_low_byte[n] <= bus.wdata;
            else count_low_byte[n] <= next_low[n];
            if (wr_high[n]) count_high_byte[n] <= bus.wdata;
            else if (n == 0 && split_en) count_high_byte[n] <= next_split_high;
            else count_high_byte[n] <= next_high[n];
         end
      end
   end

   //****************************************************************
   // Overflow and edge flags
   //****************************************************************
   // R9: split high byte drives timer 1 flag
   assign flag_set[0] = ovf[0];
   assign flag_set[1] = split0 ? ovf_split : ovf[1];
   assign pwm_flag_mode[0] = (mode[0] == DTC_MODE_PWM);
   assign pwm_flag_mode[1] = (mode[1] == DTC_MODE_PWM) && !split0;

   for (genvar n = 0; n < 2; n++) begin : g_flag
      // R16: set on overflow, cleared by ack or software, set wins
      always_ff @(posedge clock) begin
         if (sys_rst) overflow_flag[n] <= 1'b0;
         // R12: low for high-byte clocks; R15: hardware set and clear
         else if (pwm_flag_mode[n] && cnt_en[n])
            overflow_flag[n] <= (next_low[n] >= count_high_byte[n]);
         else if (!pwm_flag_mode[n] && flag_set[n]) overflow_flag[n] <= 1'b1;
         else if (wr_ctrl) overflow_flag[n] <= bus.wdata[CTRL_TF[n]];
         else if (n == 0 ? irq_ack.tf0 : irq_ack.tf1) overflow_flag[n] <= 1'b0;
      end

      // R19: edge flag, set wins over clears
      always_ff @(posedge clock) begin
         if (sys_rst) irq_edge_flag[n] <= 1'b0;
         else if (irq_type_select[n] ? ext_fall[n] : ~ext_level[n]) irq_edge_flag[n] <= 1'b1;
         else if (wr_ctrl) irq_edge_flag[n] <= bus.wdata[CTRL_IE[n]];
         else if (n == 0 ? irq_ack.ie0 : irq_ack.ie1) irq_edge_flag[n] <= 1'b0;
      end

      // Count/PWM/toggle pin driver
      always_ff @(posedge clock) begin
         if (sys_rst) begin
            count_pin_out[n] <= 1'b1;
            count_pin_oe[n]  <= 1'b0;
         end else begin
            count_pin_oe[n] <= ~timer_mode_reg[MODE_STRIDE*n + MODE_CT]
                               & (toggle_enable[n] | (mode[n] == DTC_MODE_PWM));
            // R14: forced levels for 00h and FFh
            if (mode[n] == DTC_MODE_PWM)
               count_pin_out[n] <= (count_high_byte[n] == BYTE_ZERO) ||
                                   ((count_high_byte[n] != BYTE_MAX) &&
                                    (count_low_byte[n] >= count_high_byte[n]));
            // R21: pin is 1 until the first overflow
            else if (!toggle_enable[n]) count_pin_out[n] <= 1'b1;
            // R20: invert on each overflow
            else if (ovf[n]) count_pin_out[n] <= ~count_pin_out[n];
         end
      end
   end

   assign irq_flags = '{tf1: overflow_flag[1], tf0: overflow_flag[0],
                        ie1: irq_edge_flag[1], ie0: irq_edge_flag[0]};

   //****************************************************************
   // Read data, one cycle after the read strobe
   //****************************************************************
   always_ff @(posedge clock) begin
      if (sys_rst) rdata <= REG_RESET;
      else if (!bus.rd) rdata <= REG_RESET;
      else if (bus.addr == ADDR_CONTROL)
         rdata <= {overflow_flag[1], run_bit[1], overflow_flag[0], run_bit[0],
                   irq_edge_flag[1], irq_type_select[1], irq_edge_flag[0], irq_type_select[0]};
      else if (bus.addr == ADDR_MODE) rdata <= timer_mode_reg;
      else if (bus.addr == ADDR_AUX_MODE) rdata <= {3'h0, timer_aux_mode_reg[1], 3'h0, timer_aux_mode_reg[0]};
      else if (bus.addr == ADDR_AUX_CTRL) rdata <= {6'h00, toggle_enable};
      else if (bus.addr == ADDR_LOW[0]) rdata <= count_low_byte[0];
      else if (bus.addr == ADDR_LOW[1]) rdata <= count_low_byte[1];
      else if (bus.addr == ADDR_HIGH[0]) rdata <= count_high_byte[0];
      else if (bus.addr == ADDR_HIGH[1]) rdata <= count_high_byte[1];
      else rdata <= REG_RESET;
   end

   //****************************************************************
   // Assertions
   //****************************************************************
   // R6: reload and flag on low byte overflow
   AST_RELOAD: assert property (@(posedge clock) disable iff (sys_rst) // R6
      (mode[0] == DTC_MODE_RELOAD && cnt_en[0] && count_low_byte[0] == BYTE_MAX && !wr_low[0] && !wr_ctrl)
      |=> (count_low_byte[0] == $past(count_high_byte[0])) && overflow_flag[0])
      else $error("reload did not load high byte");

   // R3: held when not enabled
   AST_GATE_HOLD: assert property (@(posedge clock) disable iff (sys_rst) // R3
      (!cnt_en[0] && !split_en && !wr_low[0] && !wr_high[0]) |=> $stable(count_low_byte[0]) && $stable(count_high_byte[0]))
      else $error("timer 0 counted while disabled");

   // R4: run set keeps counts
   AST_RUN_KEEP: assert property (@(posedge clock) disable iff (sys_rst) // R4
      (wr_ctrl && bus.wdata[CTRL_TR[1]] && !run_bit[1] && !split0 && !wr_low[1] && !wr_high[1])
      |=> count_low_byte[1] == $past(count_low_byte[1]) && count_high_byte[1] == $past(count_high_byte[1]))
      else $error("run set changed count");

   // R7: timer 1 stopped in its mode 3
   AST_T1_STOP: assert property (@(posedge clock) disable iff (sys_rst) // R7
      (mode[1] == DTC_MODE_SPLIT && !wr_low[1] && !wr_high[1]) |=> $stable(count_low_byte[1]))
      else $error("timer 1 counted in mode 3");

   // R2: prescaler holds high byte
   AST_PRESCALE: assert property (@(posedge clock) disable iff (sys_rst) // R2
      (mode[0] == DTC_MODE_13BIT && count_low_byte[0][4:0] != LOW5_MAX && !wr_high[0]) |=> $stable(count_high_byte[0]))
      else $error("high byte moved before prescaler wrap");

   // R16: overflow sets flag
   AST_OVF_FLAG: assert property (@(posedge clock) disable iff (sys_rst) // R16
      (ovf[0] && !pwm_flag_mode[0]) |=> overflow_flag[0])
      else $error("overflow flag not set");

   // R19: falling edge sets edge flag
   AST_EDGE_FLAG: assert property (@(posedge clock) disable iff (sys_rst) // R19
      (irq_type_select[1] && ext_fall[1]) |=> irq_edge_flag[1])
      else $error("edge flag not set");

   // R20: overflow inverts the pin
   AST_TOGGLE: assert property (@(posedge clock) disable iff (sys_rst) // R20
      (toggle_enable[0] && mode[0] != DTC_MODE_PWM && ovf[0]) |=> count_pin_out[0] != $past(count_pin_out[0]))
      else $error("pin did not toggle");

   // R21: pin starts high
   AST_TOGGLE_INIT: assert property (@(posedge clock) disable iff (sys_rst) // R21
      ($rose(toggle_enable[0]) && mode[0] != DTC_MODE_PWM) |-> count_pin_out[0])
      else $error("toggle pin not high at enable");

   // R14: forced low for FFh
   AST_PWM_LOW: assert property (@(posedge clock) disable iff (sys_rst) // R14
      (mode[1] == DTC_MODE_PWM && count_high_byte[1] == BYTE_MAX) |=> !count_pin_out[1])
      else $error("pwm pin not forced low");

   // R26: pin counted at most once per machine cycle
   AST_COUNT_RATE: assert property (@(posedge clock) disable iff (sys_rst) // R26
      cnt_fall[0] |=> !cnt_fall[0])
      else $error("count pin counted twice in a row");

   // R9: split high byte wrap sets timer 1 flag
   AST_SPLIT_TF1: assert property (@(posedge clock) disable iff (sys_rst) // R9
      (split_en && count_high_byte[0] == BYTE_MAX && !wr_high[0]) |=> overflow_flag[1])
      else $error("split wrap did not set flag");

   // R8: split low byte holds without its run bit
   AST_SPLIT_HOLD: assert property (@(posedge clock) disable iff (sys_rst) // R8
      (split0 && !run_bit[0] && !wr_low[0]) |=> $stable(count_low_byte[0]))
      else $error("split low byte counted");

   // R24: counter mode moves only on pin events
   AST_PIN_ONLY: assert property (@(posedge clock) disable iff (sys_rst) // R24
      (timer_mode_reg[MODE_CT] && !cnt_fall[0] && !wr_low[0]) |=> $stable(count_low_byte[0]))
      else $error("counter moved without pin edge");

   // R12: mode 6 flag high once the count reaches the high byte
   AST_PWM_FLAG: assert property (@(posedge clock) disable iff (sys_rst) // R12
      (pwm_flag_mode[1] && cnt_en[1] && !wr_low[1] && !wr_high[1])
      |=> overflow_flag[1] == (count_low_byte[1] >= count_high_byte[1]))
      else $error("pwm flag wrong");

   // R14: forced high for 00h
   AST_PWM_HIGH: assert property (@(posedge clock) disable iff (sys_rst) // R14
      (mode[1] == DTC_MODE_PWM && count_high_byte[1] == BYTE_ZERO) |=> count_pin_out[1])
      else $error("pwm pin not forced high");

endmodule : dtc_timer_core
